// ===== rtl/can_message_node.sv
`timescale 1ns/1ps
`include "can_node_defs.svh"

module can_message_node
   import can_node_pkg::*;
#(
   parameter int unsigned HB_PERIOD = `HB_PERIOD_CYCLES,
   parameter int unsigned HB_TIMEOUT = `HB_TIMEOUT_CYCLES,
   parameter int unsigned TX_TYPE = `TX_TYPE_DEFAULT
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic node_id_sel,
   input wire logic [6:0] node_id_in,
   input wire stack_state_e stack_state,
   input wire logic fault_entry,
   input wire logic [31:0] critical_fault_bits_word,
   input wire tpdo_src_s tpdo_src,
   input wire logic rx_valid,
   input wire can_frame_s rx_frame,
   input wire logic tx_ready,
   output logic tx_valid,
   output can_frame_s tx_frame,
   output ctrl_req_s ctrl,
   output logic ctrl_update,
   output logic [7:0] master_heartbeat_status,
   output logic [7:0] slave_heartbeat_status,
   output logic comm_timeout
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [10:0] frame_id(input logic [10:0] ofs,
                                            input logic [6:0] node);
      return ofs + {4'h0, node};
   endfunction

   function automatic logic [10:0] tpdo_ofs(input logic [2:0] idx);
      case (idx)
         3'h0: return `OFS_TPDO0;
         3'h1: return `OFS_TPDO1;
         3'h2: return `OFS_TPDO2;
         3'h3: return `OFS_TPDO3;
         3'h4: return `OFS_TPDO4;
         3'h5: return `OFS_TPDO5;
         3'h6: return `OFS_TPDO6;
         default: return `OFS_TPDO7;
      endcase
   endfunction

   function automatic logic [63:0] tpdo_data(input logic [2:0] idx,
                                             input tpdo_src_s s);
      if (idx == 3'h0) begin
         return {s.fault_word, s.state_word};
      end
      return s.meas[idx];
   endfunction

   function automatic logic [7:0] hb_code(input stack_state_e st);
      case (st)
         STACK_OPER: return `HB_OPER;
         STACK_STOP: return `HB_STOP;
         default: return `HB_PREOP;
      endcase
   endfunction

   localparam logic [7:0] SYNC_LAST = 8'(TX_TYPE - 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [6:0] node_id;
   logic boot_pending;
   logic hb_pending;
   logic emcy_pending;
   logic [31:0] emcy_word;
   logic burst_pending;
   logic [2:0] tpdo_idx;
   logic [7:0] sync_count;
   logic timeout_q;

   logic [6:0] next_node_id;
   logic next_tx_valid;
   can_frame_s next_tx_frame;
   ctrl_req_s next_ctrl;
   logic next_ctrl_update;
   logic [7:0] next_master_status;
   logic [7:0] next_slave_status;
   logic next_boot_pending;
   logic next_hb_pending;
   logic next_emcy_pending;
   logic [31:0] next_emcy_word;
   logic next_burst_pending;
   logic [2:0] next_tpdo_idx;
   logic [7:0] next_sync_count;

   logic hb_tick;
   logic rx_sync;
   logic rx_mhb;
   logic rx_ctl0;
   logic rx_ctl1;
   logic sync_fire;
   logic emcy_trig;

   period_tick #(.PERIOD(HB_PERIOD)) u_hb_tick (
      .clock(clock),
      .rst_n(rst_n),
      .tick(hb_tick)
   );

   heartbeat_watchdog #(.TIMEOUT(HB_TIMEOUT)) u_watchdog (
      .clock(clock),
      .rst_n(rst_n),
      .kick(rx_mhb),
      .expired(comm_timeout)
   );

   // ----------------------------------------------------------------
   // receive decode
   // ----------------------------------------------------------------
   // the reserved 0x400 frame and unknown identifiers change nothing
   assign rx_sync = rx_valid && rx_frame.id == `ID_SYNC
                    && rx_frame.dlc == `DLC_SYNC;
   assign rx_mhb = rx_valid
                   && rx_frame.id == frame_id(`OFS_HEARTBEAT, `MASTER_NODE_ID)
                   && rx_frame.dlc == `DLC_HB;
   assign rx_ctl0 = rx_valid && rx_frame.id == frame_id(`OFS_RX0, node_id)
                    && rx_frame.dlc == `DLC_FULL;
   assign rx_ctl1 = rx_valid && rx_frame.id == frame_id(`OFS_RX1, node_id)
                    && rx_frame.dlc == `DLC_FULL;
   assign sync_fire = rx_sync && sync_count == SYNC_LAST;
   assign emcy_trig = fault_entry || (comm_timeout && !timeout_q);

   always_comb begin
      next_node_id = node_id_sel ? node_id_in : `NODE_ID_DEFAULT;
      next_ctrl = ctrl;
      next_ctrl_update = rx_ctl0 || rx_ctl1;
      next_master_status = master_heartbeat_status;
      if (rx_mhb) begin
         next_master_status = rx_frame.data[7:0];
      end
      if (rx_ctl0) begin
         next_ctrl.state_req = rx_frame.data[`RX0_STATE_LSB +: 8];
         next_ctrl.mode_req = rx_frame.data[`RX0_MODE_LSB +: 8];
         next_ctrl.grid_conf = rx_frame.data[`RX0_GRID_LSB +: 8];
         next_ctrl.v_batt_set = rx_frame.data[`RX0_VSET_LSB +: 16];
      end
      if (rx_ctl1) begin
         next_ctrl.i_chg_lim = rx_frame.data[`RX1_ICHG_LSB +: 16];
         next_ctrl.i_dis_lim = rx_frame.data[`RX1_IDIS_LSB +: 16];
         next_ctrl.p_set = rx_frame.data[`RX1_PSET_LSB +: 16];
      end
   end

   // ----------------------------------------------------------------
   // transmit scheduling
   // ----------------------------------------------------------------
   // a frame is held until tx_ready; a new one loads only into an empty
   // slot, boot first, then emergency, heartbeat, process data
   always_comb begin
      next_tx_valid = tx_valid && !tx_ready;
      next_tx_frame = tx_frame;
      next_slave_status = slave_heartbeat_status;
      next_boot_pending = boot_pending;
      next_hb_pending = hb_pending;
      next_emcy_pending = emcy_pending;
      next_emcy_word = emcy_word;
      next_burst_pending = burst_pending;
      next_tpdo_idx = tpdo_idx;
      next_sync_count = sync_count;
      if (rx_sync) begin
         next_sync_count = sync_fire ? 8'h00 : sync_count + 8'h01;
      end
      if (!tx_valid) begin
         if (boot_pending) begin
            next_tx_valid = 1'b1;
            next_tx_frame = '{id: frame_id(`OFS_HEARTBEAT, node_id),
                              dlc: `DLC_HB, data: {56'h0, `HB_BOOT}};
            next_slave_status = `HB_BOOT;
            next_boot_pending = 1'b0;
         end else if (emcy_pending) begin
            next_tx_valid = 1'b1;
            next_tx_frame = '{id: frame_id(`OFS_EMCY, node_id),
                              dlc: `DLC_FULL,
                              data: {emcy_word, `EMCY_UNUSED,
                                     `EMCY_ERR_REG, `EMCY_SAFE_CODE}};
            next_emcy_pending = 1'b0;
         end else if (hb_pending) begin
            next_tx_valid = 1'b1;
            next_tx_frame = '{id: frame_id(`OFS_HEARTBEAT, node_id),
                              dlc: `DLC_HB,
                              data: {56'h0, hb_code(stack_state)}};
            next_slave_status = hb_code(stack_state);
            next_hb_pending = 1'b0;
         end else if (burst_pending) begin
            next_tx_valid = 1'b1;
            next_tx_frame = '{id: frame_id(tpdo_ofs(tpdo_idx), node_id),
                              dlc: `DLC_FULL,
                              data: tpdo_data(tpdo_idx, tpdo_src)};
            next_tpdo_idx = tpdo_idx + 3'h1;
            if (tpdo_idx == `TPDO_LAST) begin
               next_burst_pending = 1'b0;
            end
         end
      end
      // sets come after clears so a same-cycle event is kept
      if (hb_tick) begin
         next_hb_pending = 1'b1;
      end
      if (emcy_trig) begin
         next_emcy_pending = 1'b1;
         next_emcy_word = critical_fault_bits_word;
      end
      if (sync_fire) begin
         next_burst_pending = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         node_id <= `NODE_ID_DEFAULT;
         tx_valid <= 1'b0;
         tx_frame <= '0;
         ctrl <= '0;
         ctrl_update <= 1'b0;
         master_heartbeat_status <= `HB_BOOT;
         slave_heartbeat_status <= `HB_BOOT;
         boot_pending <= 1'b1;
         hb_pending <= 1'b0;
         emcy_pending <= 1'b0;
         emcy_word <= '0;
         burst_pending <= 1'b0;
         tpdo_idx <= 3'h0;
         sync_count <= 8'h00;
         timeout_q <= 1'b0;
      end else begin
         node_id <= next_node_id;
         tx_valid <= next_tx_valid;
         tx_frame <= next_tx_frame;
         ctrl <= next_ctrl;
         ctrl_update <= next_ctrl_update;
         master_heartbeat_status <= next_master_status;
         slave_heartbeat_status <= next_slave_status;
         boot_pending <= next_boot_pending;
         hb_pending <= next_hb_pending;
         emcy_pending <= next_emcy_pending;
         emcy_word <= next_emcy_word;
         burst_pending <= next_burst_pending;
         tpdo_idx <= next_tpdo_idx;
         sync_count <= next_sync_count;
         timeout_q <= comm_timeout;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_tx_hold_stable: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
      else $error("transmit frame changed before it was taken");

   a_hb_frame_form: assert property (
      tx_valid && tx_frame.id == frame_id(`OFS_HEARTBEAT, node_id)
      |-> tx_frame.dlc == `DLC_HB && tx_frame.data[63:8] == 56'h0)
      else $error("heartbeat frame has wrong length or padding");

   a_hb_status_code: assert property (
      $rose(tx_valid) && tx_frame.id == frame_id(`OFS_HEARTBEAT, node_id)
      && !$past(boot_pending)
      |-> tx_frame.data[7:0] == hb_code($past(stack_state)))
      else $error("periodic heartbeat carries wrong status");

   a_emcy_layout: assert property (
      tx_valid && tx_frame.id == frame_id(`OFS_EMCY, node_id)
      |-> tx_frame.dlc == `DLC_FULL
          && tx_frame.data[15:0] == `EMCY_SAFE_CODE)
      else $error("emergency frame has wrong code or length");

   a_emcy_on_fault: assert property (
      fault_entry |=> emcy_pending
      && emcy_word == $past(critical_fault_bits_word))
      else $error("fault entry did not queue an emergency");

   a_timeout_emcy: assert property (
      $rose(comm_timeout) |=> emcy_pending)
      else $error("heartbeat timeout did not raise an emergency");

   a_sync_burst: assert property (
      rx_sync && sync_count == SYNC_LAST |=> burst_pending)
      else $error("sync did not start a process data burst");

   a_tpdo_needs_sync: assert property (
      $rose(tx_valid) && tx_frame.id == frame_id(`OFS_TPDO0, node_id)
      |-> $past(burst_pending))
      else $error("process data sent without a sync");

   a_ctl0_capture: assert property (
      rx_ctl0 |=> ctrl.v_batt_set == $past(rx_frame.data[63:48])
      && ctrl.state_req == $past(rx_frame.data[7:0]) && ctrl_update)
      else $error("control frame 0 fields not captured");

   a_ctl1_capture: assert property (
      rx_ctl1 |=> ctrl.p_set == $past(rx_frame.data[47:32])
      && ctrl.i_chg_lim == $past(rx_frame.data[15:0]))
      else $error("control frame 1 fields not captured");

   a_foreign_ignored: assert property (
      !rx_ctl0 && !rx_ctl1 |=> $stable(ctrl) && !ctrl_update)
      else $error("unrelated frame changed the control fields");

endmodule

// ===== inc/can_node_defs.svh
// Overview of operation
// - standard 11-bit frames at 500 kbit/s; multi-byte fields least byte first
// - frame identifier is fixed offset plus node ID; node ID defaults 0x50
// - one-byte heartbeat with own status every second at offset 0x700
// - missing master heartbeat ends charge and forces fault via timeout
// - heartbeat byte: 0 once at boot, then 5, 4 or 127 by stack state
// - process data frames go out only on sync; sync is id 0x80, no data
// - each transmit frame goes after transmission-type syncs; type is 1
// - eight 8-byte transmit frames at offsets 0x180..0x480, 0x160..0x460
// - first frame: state word bytes 0-3, fault word bytes 4-7
// - emergency at offset 0x80: code, error register, unused, data bytes
// - safe fault entry sends code 0xFF01 with fault word as data
// - every entry into fault mode sends an emergency frame; entries made while one is still pending share one frame carrying the last word
// - control frame 0x200: state, mode, grid conf, reserved, voltage set
// - control frame 0x300: charge limit, discharge limit, power setpoint
// - control frame 0x400 has six bytes, all reserved
// - voltage and current fields unsigned 16-bit 0.1 units; requests bytes
// - power setpoint signed 16-bit, 10 W per count, sign gives direction
`ifndef CAN_NODE_DEFS_SVH
`define CAN_NODE_DEFS_SVH

`define NODE_ID_DEFAULT 7'h50
`define MASTER_NODE_ID 7'h01
`define ID_SYNC 11'h080
`define OFS_HEARTBEAT 11'h700
`define OFS_EMCY 11'h080
`define OFS_RX0 11'h200
`define OFS_RX1 11'h300
`define OFS_RX2 11'h400
`define OFS_TPDO0 11'h180
`define OFS_TPDO1 11'h280
`define OFS_TPDO2 11'h380
`define OFS_TPDO3 11'h480
`define OFS_TPDO4 11'h160
`define OFS_TPDO5 11'h260
`define OFS_TPDO6 11'h360
`define OFS_TPDO7 11'h460
`define TPDO_LAST 3'h7

`define DLC_SYNC 4'h0
`define DLC_HB 4'h1
`define DLC_FULL 4'h8
`define DLC_RX2 4'h6

`define HB_BOOT 8'h00
`define HB_OPER 8'h05
`define HB_STOP 8'h04
`define HB_PREOP 8'h7F

`define EMCY_SAFE_CODE 16'hFF01
`define EMCY_ERR_REG 8'h00
`define EMCY_UNUSED 8'h00

`define RX0_STATE_LSB 0
`define RX0_MODE_LSB 8
`define RX0_GRID_LSB 16
`define RX0_VSET_LSB 48
`define RX1_ICHG_LSB 0
`define RX1_IDIS_LSB 16
`define RX1_PSET_LSB 32

`define CLK_PERIOD_NS 10
`define HB_PERIOD_MS 1000
`define HB_PERIOD_CYCLES (`HB_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define HB_TIMEOUT_MS 1500
`define HB_TIMEOUT_CYCLES (`HB_TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)
`define TX_TYPE_DEFAULT 1

`endif

// ===== inc/can_node_pkg.sv
package can_node_pkg;

   // data byte i sits in bits [8*i+7:8*i]
   typedef struct packed {
      logic [10:0] id;
      logic [3:0] dlc;
      logic [63:0] data;
   } can_frame_s;

   typedef enum logic [1:0] {
      STACK_PREOP,
      STACK_OPER,
      STACK_STOP
   } stack_state_e;

   typedef struct packed {
      logic [7:0] state_req;
      logic [7:0] mode_req;
      logic [7:0] grid_conf;
      logic [15:0] v_batt_set;
      logic [15:0] i_chg_lim;
      logic [15:0] i_dis_lim;
      logic signed [15:0] p_set;
   } ctrl_req_s;

   typedef struct packed {
      logic [31:0] state_word;
      logic [31:0] fault_word;
      logic [7:1][63:0] meas;
   } tpdo_src_s;

endpackage

// ===== rtl/period_tick.sv
`timescale 1ns/1ps

module period_tick #(
   parameter int unsigned PERIOD = 1000
) (
   input wire logic clock,
   input wire logic rst_n,
   output logic tick
);

   localparam int W = $clog2(PERIOD + 1);
   localparam logic [W-1:0] LAST = W'(PERIOD - 1);

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic next_tick;

   always_comb begin
      next_count = count + W'(1);
      next_tick = 1'b0;
      if (count == LAST) begin
         next_count = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count <= '0;
         tick <= 1'b0;
      end else begin
         count <= next_count;
         tick <= next_tick;
      end
   end

   a_tick_single: assert property (@(posedge clock) disable iff (!rst_n)
      tick |=> !tick)
      else $error("period tick lasted more than one cycle");

endmodule

// ===== rtl/heartbeat_watchdog.sv
`timescale 1ns/1ps

module heartbeat_watchdog #(
   parameter int unsigned TIMEOUT = 1000
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic kick,
   output logic expired
);

   localparam int W = $clog2(TIMEOUT + 1);
   localparam logic [W-1:0] LIMIT = W'(TIMEOUT - 1);

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic next_expired;

   // expired stays up until the master heartbeat returns
   always_comb begin
      next_count = count;
      next_expired = expired;
      if (kick) begin
         next_count = '0;
         next_expired = 1'b0;
      end else if (count == LIMIT) begin
         next_expired = 1'b1;
      end else begin
         next_count = count + W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count <= '0;
         expired <= 1'b0;
      end else begin
         count <= next_count;
         expired <= next_expired;
      end
   end

   a_wdog_kick_clears: assert property (@(posedge clock) disable iff (!rst_n)
      kick |=> !expired ##1 !expired)
      else $error("watchdog expired right after a heartbeat");

endmodule

// ===== bench/can_master_model.sv
`timescale 1ns/1ps
`include "can_node_defs.svh"

module can_master_model
   import can_node_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic tx_valid,
   input wire can_frame_s tx_frame,
   output logic tx_ready,
   output logic rx_valid,
   output can_frame_s rx_frame
);
   can_frame_s out_q[$];
   can_frame_s seen_q[$];
   logic hb_on = 1'b1;
   logic slow = 1'b0;
   int hb_cnt = 0;

   task automatic send(input can_frame_s fr);
      out_q.push_back(fr);
   endtask

   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_frame = '0;
   end

   // -----------------------------------------
   // consume frames, emit own frames
   // -----------------------------------------
   always @(posedge clock) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         seen_q.push_back(tx_frame);
      end
      #1;
      tx_ready = rst_n && (!slow || $urandom_range(1));
      hb_cnt = rst_n ? hb_cnt + 1 : 0;
      if (hb_cnt >= 200) begin
         hb_cnt = 0;
         if (hb_on) begin
            out_q.push_back('{id: `OFS_HEARTBEAT + `MASTER_NODE_ID,
               dlc: `DLC_HB, data: {56'h0, `HB_OPER}});
         end
      end
      if (out_q.size() > 0 && rst_n) begin
         rx_frame = out_q.pop_front();
         rx_valid = 1'b1;
      end else begin
         // idle bus drops rx_valid and inverts the last frame each cycle
         rx_valid = 1'b0;
         rx_frame = ~rx_frame;
      end
   end
endmodule

// ===== bench/charger_can_message_node_tb_top.sv
`timescale 1ns/1ps
`include "can_node_defs.svh"

module charger_can_message_node_tb_top
   import can_node_pkg::*;
;
   localparam int unsigned HB_P = 200;
   localparam int unsigned HB_T = 350;
   localparam logic [10:0] PDO_OFS [8] = '{`OFS_TPDO0, `OFS_TPDO1,
      `OFS_TPDO2, `OFS_TPDO3, `OFS_TPDO4, `OFS_TPDO5, `OFS_TPDO6, `OFS_TPDO7};
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic node_id_sel = 1'b0;
   logic [6:0] node_id_in = 7'h00;
   stack_state_e stack_state = STACK_OPER;
   logic fault_entry = 1'b0;
   logic [31:0] critical_fault_bits_word = 32'h0;
   tpdo_src_s tpdo_src = '0;
   logic rx_valid, tx_ready, tx_valid, ctrl_update, comm_timeout;
   can_frame_s rx_frame, tx_frame, f;
   ctrl_req_s ctrl, exp_ctrl;
   logic [7:0] master_heartbeat_status, slave_heartbeat_status;
   logic [6:0] node = `NODE_ID_DEFAULT;
   logic [63:0] d0, d1;
   int miscompares = 0;
   int checks = 0;
   int upd_cnt = 0;
   int cnt0, n;
   time t0;

   always #5 clock = ~clock;
   always @(posedge clock) if (ctrl_update === 1'b1) upd_cnt++;

   can_message_node #(.HB_PERIOD(HB_P), .HB_TIMEOUT(HB_T), .TX_TYPE(1))
   can_message_node_i (.clock(clock), .rst_n(rst_n),
      .node_id_sel(node_id_sel), .node_id_in(node_id_in),
      .stack_state(stack_state), .fault_entry(fault_entry),
      .critical_fault_bits_word(critical_fault_bits_word),
      .tpdo_src(tpdo_src), .rx_valid(rx_valid), .rx_frame(rx_frame),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame),
      .ctrl(ctrl), .ctrl_update(ctrl_update),
      .master_heartbeat_status(master_heartbeat_status),
      .slave_heartbeat_status(slave_heartbeat_status),
      .comm_timeout(comm_timeout));

   can_master_model can_master_model_i (.clock(clock), .rst_n(rst_n),
      .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_frame(rx_frame));

   // -----------------------------------------
   // helpers
   // -----------------------------------------
   function automatic can_frame_s mk(input logic [10:0] id,
      input logic [3:0] dlc, input logic [63:0] data);
      return '{id: id, dlc: dlc, data: data};
   endfunction

   function automatic can_frame_s emcy(input logic [6:0] nd,
      input logic [31:0] w);
      return mk(`OFS_EMCY + nd, `DLC_FULL,
         {w, `EMCY_UNUSED, `EMCY_ERR_REG, `EMCY_SAFE_CODE});
   endfunction

   function automatic logic [7:0] hb_byte(input stack_state_e s);
      case (s)
         STACK_OPER: return `HB_OPER;
         STACK_STOP: return `HB_STOP;
         default: return `HB_PREOP;
      endcase
   endfunction

   task automatic step(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask

   task automatic check_frame(input string what, input can_frame_s exp,
      input can_frame_s got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_val(input string what, input logic [95:0] exp,
      input logic [95:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic pop_frame(input logic [10:0] skip, output can_frame_s got);
      int w;
      w = 0;
      got = '0;
      forever begin
         while (can_master_model_i.seen_q.size() == 0 && w < 3000) begin
            step(1);
            w++;
         end
         if (w >= 3000) begin
            miscompares++;
            $display("BAD frame wait expected frame seen none");
            return;
         end
         got = can_master_model_i.seen_q.pop_front();
         if (got.id !== skip) return;
      end
   endtask

   // counts frames other than own heartbeat, then empties the log
   task automatic count_pdo(output int k);
      k = 0;
      foreach (can_master_model_i.seen_q[i]) begin
         if (can_master_model_i.seen_q[i].id !== `OFS_HEARTBEAT + node) k++;
      end
      can_master_model_i.seen_q.delete();
   endtask

   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (50000) @(posedge clock);
      miscompares++;
      $display("BAD watchdog expected end seen hang");
      complete_run();
   end

   // -----------------------------------------
   // tests
   // -----------------------------------------
   initial begin
      void'($urandom(32'hA63F));
      step(20);
      rst_n = 1'b1;
      pop_frame(11'h000, f);
      check_frame("boot hb", mk(`OFS_HEARTBEAT + node, `DLC_HB,
         {56'h0, `HB_BOOT}), f);
      $display("test boot done");
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 16; k++) tpdo_src[k*32 +: 32] = $urandom;
         can_master_model_i.send(mk(`ID_SYNC, `DLC_SYNC, 64'h0));
         for (int k = 0; k < 8; k++) begin
            pop_frame(`OFS_HEARTBEAT + node, f);
            check_frame("pdo", mk(PDO_OFS[k] + node, `DLC_FULL, k == 0 ?
               {tpdo_src.fault_word, tpdo_src.state_word} :
               tpdo_src.meas[k]), f);
         end
         step(150);
         count_pdo(n);
         check_val("pdo without sync", 0, n);
         node_id_sel = 1'b1;
         node_id_in = 7'($urandom_range(2, 127));
         node = node_id_in;
         can_master_model_i.slow = 1'b1;
         step(8);
         can_master_model_i.seen_q.delete();
      end
      can_master_model_i.slow = 1'b0;
      $display("test sync bursts done");
      repeat (4) begin
         exp_ctrl = ctrl;
         d0 = {$urandom, $urandom};
         d1 = {$urandom, $urandom};
         cnt0 = upd_cnt;
         can_master_model_i.send(mk(`OFS_RX0 + node, `DLC_FULL, d0));
         can_master_model_i.send(mk(`OFS_RX1 + node, `DLC_FULL, d1));
         exp_ctrl.state_req = d0[7:0];
         exp_ctrl.mode_req = d0[15:8];
         exp_ctrl.grid_conf = d0[23:16];
         exp_ctrl.v_batt_set = d0[63:48];
         exp_ctrl.i_chg_lim = d1[15:0];
         exp_ctrl.i_dis_lim = d1[31:16];
         exp_ctrl.p_set = d1[47:32];
         step(8);
         check_val("ctrl", exp_ctrl, ctrl);
         check_val("ctrl updates", cnt0 + 2, upd_cnt);
      end
      $display("test control done");
      exp_ctrl = ctrl;
      cnt0 = upd_cnt;
      can_master_model_i.seen_q.delete();
      can_master_model_i.send(mk(`OFS_RX2 + node, `DLC_RX2,
         {$urandom, $urandom}));
      can_master_model_i.send(mk(`OFS_RX0 + node, 4'h7,
         {$urandom, $urandom}));
      can_master_model_i.send(mk(`OFS_RX1 + node + 11'h001, `DLC_FULL,
         {$urandom, $urandom}));
      can_master_model_i.send(mk(`ID_SYNC, `DLC_HB, 64'h0));
      step(60);
      check_val("ctrl kept", exp_ctrl, ctrl);
      check_val("ctrl no update", cnt0, upd_cnt);
      count_pdo(n);
      check_val("no burst", 0, n);
      $display("test ignored frames done");
      for (int s = 0; s < 3; s++) begin
         stack_state = stack_state_e'(s);
         pop_frame(11'h000, f);
         pop_frame(11'h000, f);
         t0 = $time;
         pop_frame(11'h000, f);
         check_frame("hb", mk(`OFS_HEARTBEAT + node, `DLC_HB,
            {56'h0, hb_byte(stack_state)}), f);
         check_val("hb period", HB_P, ($time - t0) / 10);
         check_val("hb status", hb_byte(stack_state),
            slave_heartbeat_status);
         check_val("master status", `HB_OPER,
            master_heartbeat_status);
      end
      $display("test heartbeat done");
      critical_fault_bits_word = $urandom;
      fault_entry = 1'b1;
      step(1);
      fault_entry = 1'b0;
      pop_frame(`OFS_HEARTBEAT + node, f);
      check_frame("emcy", emcy(node, critical_fault_bits_word),
         f);
      $display("test fault done");
      can_master_model_i.hb_on = 1'b0;
      for (int i = 0; i < 1000 && comm_timeout !== 1'b1; i++) step(1);
      check_val("timeout", 1, comm_timeout);
      pop_frame(`OFS_HEARTBEAT + node, f);
      check_frame("timeout emcy", emcy(node, critical_fault_bits_word),
         f);
      can_master_model_i.hb_on = 1'b1;
      for (int i = 0; i < 400 && comm_timeout !== 1'b0; i++) step(1);
      check_val("timeout clear", 0, comm_timeout);
      $display("test timeout done");
      complete_run();
   end
endmodule
